/* File: inc/cpi_pkg.sv */
// package: register map, field positions and timing constants for capture/periodic timer
package cpi_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TMSK_TWO   = 8'h24;
  localparam logic [7:0] ADDR_TFLG_TWO   = 8'h25;
  localparam logic [7:0] ADDR_PULSE_ACC_CONTROL_REGISTER      = 8'h26;
  localparam logic [7:0] ADDR_EDGE_CFG   = 8'h20;
  localparam logic [7:0] ADDR_COUNT      = 8'h0c;
  localparam logic [7:0] ADDR_CAP_BASE   = 8'h10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_OVF_IE    = 7;
  localparam int BIT_PER_IE    = 6;
  localparam int BIT_PAOVF_IE  = 5;
  localparam int BIT_PAEDGE_IE = 4;
  localparam int BIT_PR_HI     = 1;
  localparam int BIT_PR_LO     = 0;
  localparam int BIT_PER_FLAG  = 6;
  localparam int BIT_RATE_HI   = 1;
  localparam int BIT_RATE_LO   = 0;
  localparam logic [7:0] TMSK_WMASK = 8'hf3;
  localparam logic [7:0] TMSK_RESET = 8'h00;
  localparam logic [7:0] PULSE_ACC_CONTROL_REGISTER_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PER_BASE_LOG2 = 13;
  localparam int PER_DIV_W     = 16;
  localparam int PRESC_W       = 4;
  localparam int CNT_W         = 16;
  localparam logic [3:0] PRESC_MASK_1  = 4'h0;
  localparam logic [3:0] PRESC_MASK_4  = 4'h3;
  localparam logic [3:0] PRESC_MASK_8  = 4'h7;
  localparam logic [3:0] PRESC_MASK_16 = 4'hf;
endpackage

/* File: tb/cpi_pin_src.sv */
// capture signal source: flips selected pins between clock edges
`timescale 1ns/1ps
module cpi_pin_src (
  // clock
  input  wire logic       pclk,
  // request from the bench
  input  wire logic [2:0] flip,
  // pins to the timer
  output logic      [2:0] pin
);
  logic [2:0] f;
  initial pin = 3'b000;
  // edge lands mid-cycle so the synchroniser outcome is deterministic
  always @(posedge pclk) begin
    f = flip;
    if (f != 3'b000) #37 pin = pin ^ f;
  end
endmodule

/* File: tb/cpi_timer_properties.sv */
// checker: port-level properties of the capture/periodic timer
`timescale 1ns/1ps
module cpi_timer_props
  import cpi_pkg::*;
#(
  parameter int N_CAP = 3
) (
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // pins and requests
  input wire logic [N_CAP-1:0] capture_pin,
  input wire logic             periodic_irq,
  input wire logic             overflow_irq,
  input wire logic [N_CAP-1:0] capture_event
);
  // ---------------------------------------------------------------
  // cycles since reset release
  // ---------------------------------------------------------------
  logic [31:0] cyc_q;
  logic [31:0] cyc_d;
  wire         wr_acc = psel & penable & pwrite;
  always_comb cyc_d = cyc_q + 32'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc_q <= 32'h0;
    else cyc_q <= cyc_d;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_mask;
    psel && penable && !pwrite && paddr == ADDR_TMSK_TWO;
  endsequence
  sequence s_mask_off;
    wr_acc && paddr == ADDR_TMSK_TWO && !pwdata[BIT_PER_IE];
  endsequence
  AST_FIRST_TIMEOUT: assert property (periodic_irq |-> cyc_q >= 32'd8192)
    else $error("periodic request before a full interval");
  AST_TIMEOUT_GRID: assert property ($rose(periodic_irq) && !$past(wr_acc)
    |-> cyc_q[12:0] == 13'h0) else $error("timeout off the interval grid");
  AST_GATE_OFF: assert property (s_mask_off |=> !periodic_irq)
    else $error("periodic request with enable clear");
  AST_IRQ_HOLD: assert property ($fell(periodic_irq) |-> $past(wr_acc))
    else $error("periodic request dropped without software");
  AST_RSVD_ZERO: assert property (s_rd_mask |-> prdata[3:2] == 2'b00)
    else $error("mask bits 3..2 read nonzero");
  AST_MASK_MAPPED: assert property (s_rd_mask |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("mask register access faulted");
  AST_CAP_SYNC: assert property (capture_event[0]
    |-> $past(capture_pin[0], 3) != $past(capture_pin[0], 4)) else $error("capture latency");
  AST_CAP_PULSE: assert property (capture_event[0] |=> !capture_event[0])
    else $error("capture event longer than one cycle");
endmodule

bind cpi_timer cpi_timer_props #(.N_CAP(N_CAP)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .periodic_irq(periodic_irq), .overflow_irq(overflow_irq), .capture_event(capture_event));

/* File: tb/testbench.sv */
// self-checking bench for the capture/periodic timer
`timescale 1ns/1ps
module testbench;
  import cpi_pkg::*;
  typedef struct {string nm; logic [31:0] v; logic e;} cpi_note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        periodic_irq, overflow_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  capture_pin, capture_event, flip;
  logic [15:0] cap [2];
  int          num_errors, tests_run, ncyc, p, t;
  cpi_note_t   notes [$];
  cpi_timer #(.N_CAP(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .periodic_irq(periodic_irq), .overflow_irq(overflow_irq), .capture_event(capture_event));
  cpi_pin_src src (.pclk(pclk), .flip(flip), .pin(capture_pin));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ncyc <= 0;
    else ncyc <= ncyc + 1;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x) begin
      $display("unexpected %s: expected %h, seen %h", nm, x, got);
      num_errors++;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // read monitor: oldest note against each completed read
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      chk(notes[0].nm, notes[0].v, prdata);
      chk({notes[0].nm, " slverr"}, {31'h0, notes[0].e}, {31'h0, pslverr});
      void'(notes.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] v, input logic e);
    notes.push_back('{nm, v, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (periodic_irq !== 1'b1 && n < 70000);
    if (n >= 70000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, flip} = '0;
    num_errors = 0;
    tests_run = 0;
    void'($urandom(65710));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_TMSK_TWO, "mask", 32'h0, 1'b0);
    rd(ADDR_TFLG_TWO, "flags", 32'h0, 1'b0);
    // prescale kept at E/1 so capture values track the cycle count
    r = $urandom & 32'hffff_fffc;
    apb(1'b1, ADDR_TMSK_TWO, r);
    rd(ADDR_TMSK_TWO, "mask", {24'h0, r[7:0] & TMSK_WMASK}, 1'b0);
    rd(8'h30, "unmapped", 32'h0, 1'b1);
    apb(1'b1, ADDR_TMSK_TWO, 32'h0);
    $display("test registers done");
    apb(1'b1, ADDR_EDGE_CFG, 32'h39);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      flip <= 3'b111;
      cap[k] = 16'(ncyc + 4);
      @(posedge pclk);
      flip <= 3'b000;
      repeat (3) @(posedge pclk);
      #1;
      chk("event", {29'h0, k ? 3'b110 : 3'b101}, {29'h0, capture_event});
      @(posedge pclk);
      rd(ADDR_CAP_BASE, "cap0", {16'h0, cap[0]}, 1'b0);
      rd(ADDR_CAP_BASE + 8'h4, "cap1", k ? {16'h0, cap[1]} : 32'h0, 1'b0);
      rd(ADDR_CAP_BASE + 8'h8, "cap2", {16'h0, cap[k]}, 1'b0);
    end
    $display("test capture done");
    apb(1'b1, ADDR_TMSK_TWO, 32'h40);
    wait_irq();
    chk("first timeout", 32'd8192, ncyc);
    repeat ($urandom_range(200)) @(posedge pclk);
    apb(1'b1, ADDR_TMSK_TWO, 32'h0);
    #1;
    chk("masked request", 32'h0, {31'h0, periodic_irq});
    rd(ADDR_TFLG_TWO, "flags", 32'h40, 1'b0);
    apb(1'b1, ADDR_TMSK_TWO, 32'h40);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_TFLG_TWO, 32'h40);
      apb(1'b1, ADDR_PULSE_ACC_CONTROL_REGISTER, k);
      p = 8192 << k;
      t = (ncyc / p + 1) * p;
      wait_irq();
      chk("timeout", t, ncyc);
    end
    apb(1'b1, ADDR_PULSE_ACC_CONTROL_REGISTER, 32'h3);
    rd(ADDR_PULSE_ACC_CONTROL_REGISTER, "rate", 32'h3, 1'b0);
    rd(ADDR_TFLG_TWO, "flags at wrap", 32'hc0, 1'b0);
    apb(1'b1, ADDR_TMSK_TWO, 32'hc0);
    #1;
    chk("overflow request", 32'h1, {31'h0, overflow_irq});
    $display("test periodic done");
    repeat (2) @(posedge pclk);
    end_of_test();
  end
endmodule

/* File: verilog/cpi_timer.sv */
// capture and periodic-interrupt timer with apb register access
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - chosen edge latches counter into capture
// - synchronise inputs, latch opposite counter half; code captures pre-increment count_q on the same posedge
// - compare pin delay matches capture delay; no compare pin here, capture_event carries the synchroniser delay
// - rate select gives E/2^13..2^16
// - enable bit gates periodic interrupt request
// - periodic divider free-running, only reset stops
// - interval measured from previous timeout
// - timeout sets flag, raises irq if enabled
// - full interval before first flag after reset
// - mask register at 0x24, layout, reset zero
// - bits 3..2 read zero, writes ignored
// - prescale select divides counter clock 1/4/8/16
module cpi_timer
  import cpi_pkg::*;
#(
  parameter int N_CAP = 3
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // capture pins
  input  wire logic [N_CAP-1:0]  capture_pin,
  // interrupt requests
  output logic                   periodic_irq,
  output logic                   overflow_irq,
  output logic [N_CAP-1:0]       capture_event
);

  // ---------------------------------------------------------------
  // types and decode helpers
  // ---------------------------------------------------------------
  typedef logic [CNT_W-1:0] cpi_word_t;

  function automatic logic [3:0] presc_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    presc_mask = PRESC_MASK_1;
      2'h1:    presc_mask = PRESC_MASK_4;
      2'h2:    presc_mask = PRESC_MASK_8;
      default: presc_mask = PRESC_MASK_16;
    endcase
  endfunction

  function automatic logic is_cap_addr(input logic [7:0] a, input int idx);
    is_cap_addr = (a == 8'(ADDR_CAP_BASE + 8'(4 * idx)));
  endfunction

  // hardware set beats a software clear in the same cycle, so no event is lost
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]            tmsk_q, tmsk_d;
  logic [7:0]            pulse_acc_control_register_q, pulse_acc_control_register_d;
  logic [2*N_CAP-1:0]    edge_cfg_q, edge_cfg_d;
  logic                  per_flag_q, per_flag_d;
  logic                  ovf_flag_q, ovf_flag_d;
  logic [PER_DIV_W-1:0]  per_div_q, per_div_d;
  logic [PRESC_W-1:0]    presc_q, presc_d;
  cpi_word_t             count_q, count_d;
  cpi_word_t             cap_q [N_CAP];
  cpi_word_t             cap_d [N_CAP];
  logic [N_CAP-1:0]      sync1_q, sync2_q, sync3_q;
  logic [N_CAP-1:0]      sync1_d, sync2_d, sync3_d;
  logic [N_CAP-1:0]      cap_hit;
  logic [N_CAP-1:0]      cap_ev_q, cap_ev_d;
  logic                  per_clr;
  logic                  ovf_clr;
  logic [31:0]           rdata_q, rdata_d;

  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_ok;
  logic                  count_tick;
  logic                  per_tick;
  logic [1:0]            rate_sel;
  logic [PER_DIV_W-1:0]  per_mask;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = rdata_q;

  // ---------------------------------------------------------------
  // capture input synchronisers
  // ---------------------------------------------------------------
  // the third stage only feeds the edge detector; stage one is read by stage two alone
  always_comb begin
    sync1_d = capture_pin;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // edge select per channel: 00 off, 01 rising, 10 falling, 11 both
  genvar gi;
  generate
    for (gi = 0; gi < N_CAP; gi++) begin : g_edge
      logic rise;
      logic fall;
      assign rise = sync2_q[gi] & ~sync3_q[gi];
      assign fall = ~sync2_q[gi] & sync3_q[gi];
      assign cap_hit[gi] = (edge_cfg_q[2*gi] & rise) | (edge_cfg_q[2*gi+1] & fall);
    end
  endgenerate

  // ---------------------------------------------------------------
  // main counter with prescaler
  // ---------------------------------------------------------------
  // single-edge design: the capture takes the pre-increment value, which stands in
  // for latching on the half cycle opposite the increment
  always_comb begin
    presc_d    = presc_q + 4'h1;
    count_tick = 1'b0;
    if ((presc_q & presc_mask(tmsk_q[BIT_PR_HI:BIT_PR_LO])) ==
        presc_mask(tmsk_q[BIT_PR_HI:BIT_PR_LO])) begin
      presc_d    = '0;
      count_tick = 1'b1;
    end
    count_d    = count_tick ? count_q + 16'h0001 : count_q;
    cap_ev_d   = cap_hit;
    for (int i = 0; i < N_CAP; i++) begin
      cap_d[i] = cap_hit[i] ? count_q : cap_q[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q  <= '0;
      count_q  <= '0;
      cap_ev_q <= '0;
      for (int i = 0; i < N_CAP; i++) begin
        cap_q[i] <= '0;
      end
    end else begin
      presc_q  <= presc_d;
      count_q  <= count_d;
      cap_ev_q <= cap_ev_d;
      for (int i = 0; i < N_CAP; i++) begin
        cap_q[i] <= cap_d[i];
      end
    end
  end

  // compare outputs are outside this block; capture_event carries the same
  // fixed synchroniser latency a compare pin would see
  assign capture_event = cap_ev_q;

  // ---------------------------------------------------------------
  // periodic divider
  // ---------------------------------------------------------------
  // divider never reloads on software action, so spacing stays constant
  assign rate_sel = {pulse_acc_control_register_q[BIT_RATE_HI], pulse_acc_control_register_q[BIT_RATE_LO]};

  always_comb begin
    case (rate_sel)
      2'h0:    per_mask = 16'h1fff;
      2'h1:    per_mask = 16'h3fff;
      2'h2:    per_mask = 16'h7fff;
      default: per_mask = 16'hffff;
    endcase
    per_div_d = per_div_q + 16'h0001;
    per_tick  = ((per_div_q & per_mask) == per_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_div_q <= '0;
    end else begin
      per_div_q <= per_div_d;
    end
  end

  // ---------------------------------------------------------------
  // registers and flags
  // ---------------------------------------------------------------
  always_comb begin
    addr_ok = (paddr == ADDR_TMSK_TWO) || (paddr == ADDR_TFLG_TWO) ||
              (paddr == ADDR_PULSE_ACC_CONTROL_REGISTER) || (paddr == ADDR_EDGE_CFG) ||
              (paddr == ADDR_COUNT);
    for (int i = 0; i < N_CAP; i++) begin
      if (is_cap_addr(paddr, i)) begin
        addr_ok = 1'b1;
      end
    end
  end

  always_comb begin
    tmsk_d     = tmsk_q;
    pulse_acc_control_register_d    = pulse_acc_control_register_q;
    edge_cfg_d = edge_cfg_q;
    per_clr    = 1'b0;
    ovf_clr    = 1'b0;
    if (wr_en) begin
      case (paddr)
        ADDR_TMSK_TWO: tmsk_d     = pwdata[7:0] & TMSK_WMASK;
        ADDR_PULSE_ACC_CONTROL_REGISTER:    pulse_acc_control_register_d    = pwdata[7:0];
        ADDR_EDGE_CFG: edge_cfg_d = pwdata[2*N_CAP-1:0];
        ADDR_TFLG_TWO: begin
          // write one to clear
          per_clr = pwdata[BIT_PER_FLAG];
          ovf_clr = pwdata[7];
        end
        default: ;
      endcase
    end
    per_flag_d = flag_next(per_flag_q, per_tick, per_clr);
    ovf_flag_d = flag_next(ovf_flag_q, count_tick && (count_q == 16'hffff), ovf_clr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmsk_q     <= TMSK_RESET;
      pulse_acc_control_register_q    <= PULSE_ACC_CONTROL_REGISTER_RESET;
      edge_cfg_q <= '0;
      per_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
    end else begin
      tmsk_q     <= tmsk_d;
      pulse_acc_control_register_q    <= pulse_acc_control_register_d;
      edge_cfg_q <= edge_cfg_d;
      per_flag_q <= per_flag_d;
      ovf_flag_q <= ovf_flag_d;
    end
  end

  // ---------------------------------------------------------------
  // read data, captured in setup phase
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      rdata_d = '0;
      case (paddr)
        ADDR_TMSK_TWO: rdata_d[7:0] = tmsk_q & TMSK_WMASK;
        ADDR_TFLG_TWO: rdata_d[7:0] = {ovf_flag_q, per_flag_q, 6'h00};
        ADDR_PULSE_ACC_CONTROL_REGISTER:    rdata_d[7:0] = pulse_acc_control_register_q;
        ADDR_EDGE_CFG: rdata_d[2*N_CAP-1:0] = edge_cfg_q;
        ADDR_COUNT:    rdata_d[CNT_W-1:0] = count_q;
        default: begin
          for (int i = 0; i < N_CAP; i++) begin
            if (is_cap_addr(paddr, i)) begin
              rdata_d[CNT_W-1:0] = cap_q[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign periodic_irq = per_flag_q & tmsk_q[BIT_PER_IE];
  assign overflow_irq = ovf_flag_q & tmsk_q[BIT_OVF_IE];

endmodule
